/* File: logic/imc_defs.svh */
`ifndef IMC_DEFS_SVH
`define IMC_DEFS_SVH
// Register addresses
`define IMC_A_GEN_RESET 8'h01
`define IMC_A_SUM1_HI   8'ha9
`define IMC_A_SUM1_LO   8'haa
`define IMC_A_SUM2_HI   8'hb8
`define IMC_A_SUM2_LO   8'hb9
`define IMC_A_MODE      8'hc1
`define IMC_A_IMAGE     8'hc3
`define IMC_A_SECONDARY_STATUS   8'hc4
`define IMC_A_IDENT     8'hc5
`define IMC_A_STATUS    8'hc6
`define IMC_A_CMD       8'hc8
`define IMC_A_VER_ADC   8'hc9
`define IMC_A_MASK      8'hce
// Status bits
`define IMC_ST_READY    0
`define IMC_ST_DATA     1
`define IMC_ST_MODEM    2
`define IMC_ST_INVALID  3
`define IMC_ST_IRQ      15
`define IMC_ST2_SLEEP   13
`define IMC_LOCK_MARK   16'hdead
// Command fields and task codes
`define IMC_DATA_F      15:8
`define IMC_MODEM_F     7:0
`define IMC_CFG_BIT     7
`define IMC_T_NULL      8'h00
`define IMC_T_BURST     8'h01
`define IMC_T_ENTER_CFG 8'h02
`define IMC_T_LEAVE_SLP 8'h81
`define IMC_T_EXIT_CFG  8'h82
`define IMC_T_ENTER_SLP 8'h83
// Mode register and converter result
`define IMC_ADC_SEL     0
`define IMC_ADC_TAG     12
`define IMC_ADC_CYC     8'd63
`define IMC_DATA_CYC    8'd4
// Serial frame
`define IMC_ADDR_BITS   5'd8
`define IMC_FRAME_BITS  5'd24
// Timing
`define IMC_SYS_HZ      25000000
`define IMC_TICK_HZ     24000
`define IMC_TICK_CYC    11'(`IMC_SYS_HZ / `IMC_TICK_HZ)
`define IMC_SLOT_US     50
`define IMC_SLOT_HI_CYC ((`IMC_SLOT_US * (`IMC_SYS_HZ / 1000000)))
`define IMC_IMAGE_BYTES 24576
`endif

/* File: logic/imc_pkg.sv */
package imc_pkg;
`include "imc_defs.svh"
	typedef enum logic [2:0] {IMC_LOAD, IMC_AWAIT, IMC_SLEEP, IMC_CONFIG, IMC_NORMAL} imc_mode_t;
	typedef enum logic [1:0] {IMC_H_IDLE, IMC_H_SHIFT, IMC_H_GAP, IMC_H_END} imc_hstate_t;

	// Registers the host reads; every other address is written
	function automatic logic imc_is_read(input logic [7:0] a);
		return a == `IMC_A_SUM1_HI || a == `IMC_A_SUM1_LO || a == `IMC_A_SUM2_HI ||
			a == `IMC_A_SUM2_LO || a == `IMC_A_IDENT || a == `IMC_A_STATUS ||
			a == `IMC_A_SECONDARY_STATUS || a == `IMC_A_VER_ADC;
	endfunction
endpackage

/* File: logic/imc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface imc_link_if;
	logic sclk;
	logic csn;
	logic cdata;
	logic rdata_dev;
	logic rdata_oe;
	logic slot_pulse;
	logic irq_dev;
	logic irq_oe;
	wire  rdata = rdata_oe ? rdata_dev : 1'b1;
	// Open-drain interrupt with pull-up, active low
	wire  host_interrupt_line = irq_oe ? irq_dev : 1'b1;
	modport device (input sclk, csn, cdata, slot_pulse, output rdata_dev, rdata_oe, irq_dev, irq_oe);
	modport host (output sclk, csn, cdata, slot_pulse, input rdata, host_interrupt_line);
endinterface
`default_nettype wire

/* File: logic/imc_device.sv */
// Contract
// - Image holds at most 24 kilobytes.
// - Loaded image shows identity and version.
// - Two 32-bit checksums in register pairs.
// - Wait for 32-bit unlock code.
// - Valid code: sleep, set ready bit 0.
// - Sleep shown in secondary status bit 13.
// - Host powers analogue before leaving sleep.
// - Unlock clears checksum, identity, version.
// - Bad code: show DEAD, ignore all writes.
// - After reset, reload and unlock again.
// - Host waits ready bit before image.
// - Leave-sleep to normal; sleep via config.
// - Enter/exit configuration mode tasks.
// - Config disables modem; wrong-mode tasks invalid.
// - Command write replaces both task fields.
// - Data task completes before modem task; in config mode the modem task acts on the write itself.
// - Host slot pulse, 50us, 37.5Hz.
// - Timing counted in 24kHz ticks.
// - Burst schedules modulation, ramp, enable, sensing.
// - Converter result with input tag.
// - Interrupt low when status15 and mask15.
// - Sleep stops processing, bus stays alive.
// - Serial bits travel MSB first.
`timescale 1ns/1ps
`default_nettype none
`include "imc_defs.svh"
module imc_device #(
	parameter int unsigned IMAGE_WORDS  = `IMC_IMAGE_BYTES / 2,
	parameter logic [31:0] UNLOCK_CODE  = 32'h1234_5678,
	parameter logic [15:0] PRODUCT_ID   = 16'h00a5,
	parameter logic [15:0] SENSE_ON     = 16'd1,
	parameter logic [15:0] SENSE_OFF    = 16'd4,
	parameter logic [15:0] TXEN_ON      = 16'd6,
	parameter logic [15:0] RAMP_ON      = 16'd8,
	parameter logic [15:0] MOD_ON       = 16'd10,
	parameter logic [15:0] MOD_OFF      = 16'd250,
	parameter logic [15:0] RAMP_OFF     = 16'd252,
	parameter logic [15:0] TXEN_OFF     = 16'd256
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        clk_en_in,
	imc_link_if.device       link,
	input  wire logic [9:0]  aux_a_in,
	input  wire logic [9:0]  aux_b_in,
	output logic             modulation_out,
	output logic             ramp_up_out,
	output logic             tx_enable_out,
	output logic             carrier_sense_out,
	output imc_pkg::imc_mode_t mode_out
);
	import imc_pkg::*;

	typedef struct packed {
		imc_mode_t   mode;
		logic        lock;
		logic [14:0] words;
		logic [31:0] sum_a;
		logic [31:0] sum_b;
		logic [15:0] version;
		logic [15:0] code_hi;
		logic        code_half;
		logic [2:0]  sticky;
		logic [15:0] mask;
		logic [15:0] mode_reg;
		logic [7:0]  pend_modem;
		logic [7:0]  data_busy;
		logic [15:0] rd_word;
		logic [2:0]  ev_sync;
		logic [2:0]  slot_sync;
		logic [10:0] tick_div;
		logic [15:0] tick;
		logic        armed;
		logic        run;
		logic [7:0]  adc_div;
		logic [15:0] adc_result;
		logic [3:0]  pins;
	} imc_sys_t;

	typedef struct packed {
		logic [4:0]  cnt;
		logic [15:0] sh;
		logic [7:0]  addr;
		logic        rd;
	} imc_frame_t;

	typedef struct packed {
		logic        tgl;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] data;
	} imc_evt_t;

	imc_sys_t   s, next_s;
	imc_frame_t f, next_f;
	imc_evt_t   e, next_e;
	logic       frame_clr;
	logic       ev;
	logic       slot_rise;
	logic [15:0] st_w;
	logic [3:0] idx;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain, clocked by the serial clock; chip select high clears the frame
	assign frame_clr = !rst_n_in || link.csn;

	// Shift in MSB first, raise an event on a read or reset address or a full write
	always_comb begin
		next_f = f;
		next_e = e;
		next_f.sh = {f.sh[14:0], link.cdata};
		if (f.cnt != `IMC_FRAME_BITS) next_f.cnt = f.cnt + 5'd1;
		if (f.cnt == `IMC_ADDR_BITS - 5'd1) begin
			next_f.addr = next_f.sh[7:0];
			next_f.rd = imc_is_read(next_f.sh[7:0]);
			if (next_f.rd || next_f.sh[7:0] == `IMC_A_GEN_RESET) begin
				next_e.tgl = ~e.tgl;
				next_e.rd = next_f.rd;
				next_e.addr = next_f.sh[7:0];
				next_e.data = '0;
			end
		end else if (f.cnt == `IMC_FRAME_BITS - 5'd1 && !f.rd) begin
			next_e.tgl = ~e.tgl;
			next_e.rd = 1'b0;
			next_e.addr = f.addr;
			next_e.data = next_f.sh;
		end
	end

	// Frame counter dies with the frame, events survive it
	always_ff @(posedge link.sclk or posedge frame_clr) begin
		if (frame_clr) f <= '0;
		else f <= next_f;
	end

	always_ff @(posedge link.sclk or negedge rst_n_in) begin
		if (!rst_n_in) e <= '0;
		else e <= next_e;
	end

	// Read word is loaded well before the host clocks it out, so it is stable here
	assign idx = 4'(f.cnt - `IMC_ADDR_BITS);
	assign link.rdata_dev = s.rd_word[4'd15 - idx];
	assign link.rdata_oe = f.rd && !link.csn && f.cnt >= `IMC_ADDR_BITS &&
		f.cnt < `IMC_FRAME_BITS;

	////////////////////////////////////////////////////////////////////////////////
	// System domain
	always_comb begin
		st_w = '0;
		st_w[`IMC_ST_READY] = !s.lock && s.mode != IMC_AWAIT;
		st_w[`IMC_ST_DATA] = s.sticky[0];
		st_w[`IMC_ST_MODEM] = s.sticky[1];
		st_w[`IMC_ST_INVALID] = s.sticky[2];
		st_w[`IMC_ST_IRQ] = |s.sticky;
	end

	// Event edge uses only the second and third sync stages
	assign ev = s.ev_sync[1] ^ s.ev_sync[2];
	assign slot_rise = s.slot_sync[1] && !s.slot_sync[2];

	always_comb begin
		next_s = s;
		next_s.ev_sync = {s.ev_sync[1:0], e.tgl};
		next_s.slot_sync = {s.slot_sync[1:0], link.slot_pulse};
		// Read request: load the word the link will shift out
		if (ev && e.rd) begin
			if (e.addr == `IMC_A_SUM1_HI) begin
				next_s.rd_word = s.lock ? `IMC_LOCK_MARK : s.sum_a[31:16];
			end else if (e.addr == `IMC_A_SUM1_LO) begin
				next_s.rd_word = s.sum_a[15:0];
			end else if (e.addr == `IMC_A_SUM2_HI) begin
				next_s.rd_word = s.sum_b[31:16];
			end else if (e.addr == `IMC_A_SUM2_LO) begin
				next_s.rd_word = s.sum_b[15:0];
			end else if (e.addr == `IMC_A_IDENT) begin
				next_s.rd_word = s.mode == IMC_AWAIT ? PRODUCT_ID : 16'h0000;
			end else if (e.addr == `IMC_A_STATUS) begin
				next_s.rd_word = st_w;
				next_s.sticky = '0; // Later sets in this cycle win
			end else if (e.addr == `IMC_A_SECONDARY_STATUS) begin
				next_s.rd_word = '0;
				next_s.rd_word[`IMC_ST2_SLEEP] = s.mode == IMC_SLEEP;
			end else if (e.addr == `IMC_A_VER_ADC) begin
				next_s.rd_word = s.mode == IMC_AWAIT ? s.version : s.adc_result;
			end else begin
				next_s.rd_word = '0;
			end
		end
		// Data unit countdown, then the queued modem task
		if (s.data_busy != 8'h00) begin
			next_s.data_busy = s.data_busy - 8'd1;
			if (s.data_busy == 8'd1) next_s.sticky[0] = 1'b1;
		end else if (s.pend_modem != `IMC_T_NULL) begin
			next_s.pend_modem = `IMC_T_NULL;
			if (s.pend_modem == `IMC_T_ENTER_CFG) begin
				next_s.mode = IMC_CONFIG;
				next_s.armed = 1'b0;
				next_s.run = 1'b0;
				next_s.sticky[1] = 1'b1;
			end else if (s.pend_modem == `IMC_T_BURST) begin
				next_s.armed = 1'b1;
			end else begin
				next_s.sticky[2] = 1'b1;
			end
		end
		// Slot timebase, burst sequence and converter all halt in sleep
		if (s.mode != IMC_SLEEP) begin
			if (slot_rise) begin
				next_s.tick_div = '0;
				next_s.tick = '0;
				next_s.run = s.armed;
				next_s.armed = 1'b0;
			end else if (s.tick_div == `IMC_TICK_CYC - 11'd1) begin
				next_s.tick_div = '0;
				if (s.tick != 16'hffff) next_s.tick = s.tick + 16'd1;
			end else begin
				next_s.tick_div = s.tick_div + 11'd1;
			end
			if (s.run && s.tick == TXEN_OFF) begin
				next_s.run = 1'b0;
				next_s.sticky[1] = 1'b1;
			end
			next_s.adc_div = s.adc_div == 8'h00 ? `IMC_ADC_CYC : s.adc_div - 8'd1;
			if (s.adc_div == 8'h00) begin
				next_s.adc_result = '0;
				next_s.adc_result[9:0] = s.mode_reg[`IMC_ADC_SEL] ? aux_b_in : aux_a_in;
				next_s.adc_result[`IMC_ADC_TAG] = s.mode_reg[`IMC_ADC_SEL];
			end
		end
		// Burst pins are windows on the tick count; modem only runs in normal mode
		next_s.pins[0] = s.run && s.mode == IMC_NORMAL && s.tick >= MOD_ON && s.tick < MOD_OFF;
		next_s.pins[1] = s.run && s.mode == IMC_NORMAL && s.tick >= RAMP_ON &&
			s.tick < RAMP_OFF;
		next_s.pins[2] = s.run && s.mode == IMC_NORMAL && s.tick >= TXEN_ON &&
			s.tick < TXEN_OFF;
		next_s.pins[3] = s.run && s.mode == IMC_NORMAL && s.tick >= SENSE_ON &&
			s.tick < SENSE_OFF;
		// Writes; a locked device decodes none of them
		if (ev && !e.rd && !s.lock) begin
			if (e.addr == `IMC_A_GEN_RESET) begin
				next_s = '0;
				next_s.ev_sync = {s.ev_sync[1:0], e.tgl};
				next_s.slot_sync = {s.slot_sync[1:0], link.slot_pulse};
				next_s.rd_word = s.rd_word;
			end else if (e.addr == `IMC_A_IMAGE) begin
				if (s.mode == IMC_LOAD && 32'(s.words) < IMAGE_WORDS) begin
					next_s.sum_a = s.sum_a + {16'h0000, e.data};
					next_s.sum_b = {s.sum_b[30:0], s.sum_b[31]} ^ {16'h0000, e.data};
					if (s.words == '0) next_s.version = e.data;
					next_s.words = s.words + 15'd1;
					if (32'(s.words) == IMAGE_WORDS - 1) next_s.mode = IMC_AWAIT;
				end
			end else if (e.addr == `IMC_A_MASK) begin
				next_s.mask = e.data;
			end else if (e.addr == `IMC_A_MODE) begin
				next_s.mode_reg = e.data;
			end else if (e.addr == `IMC_A_CMD) begin
				case (s.mode)
					IMC_AWAIT: begin
						next_s.code_hi = e.data;
						next_s.code_half = !s.code_half;
						if (s.code_half && {s.code_hi, e.data} == UNLOCK_CODE) begin
							next_s.mode = IMC_SLEEP;
							next_s.sum_a = '0;
							next_s.sum_b = '0;
							next_s.version = '0;
						end else if (s.code_half) begin
							next_s.lock = 1'b1;
						end
					end
					IMC_SLEEP: begin
						if (e.data[`IMC_MODEM_F] == `IMC_T_LEAVE_SLP) next_s.mode = IMC_NORMAL;
						else next_s.sticky[2] = 1'b1;
					end
					IMC_CONFIG: begin
						if (e.data[`IMC_DATA_F] != `IMC_T_NULL) next_s.data_busy = `IMC_DATA_CYC;
						if (e.data[`IMC_MODEM_F] == `IMC_T_EXIT_CFG) begin
							next_s.mode = IMC_NORMAL;
						end else if (e.data[`IMC_MODEM_F] == `IMC_T_ENTER_SLP) begin
							next_s.mode = IMC_SLEEP;
						end else if (e.data[`IMC_MODEM_F] != `IMC_T_NULL) begin
							next_s.sticky[2] = 1'b1;
						end
					end
					IMC_NORMAL: begin
						if (e.data[`IMC_DATA_F] != `IMC_T_NULL) next_s.data_busy = `IMC_DATA_CYC;
						if (e.data[`IMC_CFG_BIT]) begin
							next_s.sticky[2] = 1'b1;
							next_s.pend_modem = `IMC_T_NULL;
						end else begin
							next_s.pend_modem = e.data[`IMC_MODEM_F];
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Lockout lives in the same register set, so only the reset pin clears it
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) s <= '0;
		else if (clk_en_in) s <= next_s;
	end

	assign link.irq_dev = 1'b0;
	assign link.irq_oe = st_w[`IMC_ST_IRQ] && s.mask[`IMC_ST_IRQ];
	assign modulation_out = s.pins[0];
	assign ramp_up_out = s.pins[1];
	assign tx_enable_out = s.pins[2];
	assign carrier_sense_out = s.pins[3];
	assign mode_out = s.mode;
endmodule
`default_nettype wire

/* File: logic/imc_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "imc_defs.svh"
module imc_host #(
	parameter int unsigned  IMAGE_WORDS = `IMC_IMAGE_BYTES / 2,
	parameter logic [7:0]   SCLK_HALF   = 8'd4,
	parameter logic [7:0]   GAP_CYC     = 8'd12,
	parameter logic [19:0]  SLOT_CYC    = 20'd666667
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        clk_en_in,
	imc_link_if.host         link,
	input  wire logic        req_valid_in,
	input  wire logic        req_write_in,
	input  wire logic [7:0]  req_addr_in,
	input  wire logic [15:0] req_data_in,
	output logic             req_ready_out,
	output logic             rsp_valid_out,
	output logic [15:0]      rsp_data_out,
	input  wire logic        analog_power_req_in,
	output logic             analog_power_out,
	output logic             irq_out
);
	import imc_pkg::*;

	typedef struct packed {
		imc_hstate_t st;
		logic [7:0]  div;
		logic [4:0]  bitn;
		logic [4:0]  last;
		logic        rd;
		logic [23:0] sh;
		logic [15:0] rsh;
		logic [2:0]  rsync;
		logic [2:0]  isync;
		logic        sclk;
		logic        csn;
		logic        rsp;
		logic        ready_seen;
		logic        sleep_seen;
		logic        power;
		logic [14:0] words;
		logic [19:0] slot;
		logic [7:0]  addr;
	} imc_host_t;

	imc_host_t h, next_h;
	logic      take;
	logic      allowed;

	// Image only after ready seen, within size; leave-sleep only with power on
	always_comb begin
		allowed = 1'b1;
		if (req_write_in && req_addr_in == `IMC_A_IMAGE) begin
			allowed = h.ready_seen && 32'(h.words) < IMAGE_WORDS;
		end else if (req_write_in && req_addr_in == `IMC_A_CMD &&
			req_data_in[`IMC_MODEM_F] == `IMC_T_LEAVE_SLP) begin
			allowed = h.power;
		end
	end
	assign req_ready_out = h.st == IMC_H_IDLE && allowed;
	assign take = req_valid_in && req_ready_out;

	////////////////////////////////////////////////////////////////////////////////
	// Serial master: clock divided down from the system clock, MSB first
	always_comb begin
		next_h = h;
		next_h.rsp = 1'b0;
		next_h.rsync = {h.rsync[1:0], link.rdata};
		next_h.isync = {h.isync[1:0], link.host_interrupt_line};
		next_h.slot = h.slot == SLOT_CYC - 20'd1 ? '0 : h.slot + 20'd1;
		// Power drops only once sleep was seen; rising is always allowed
		if (analog_power_req_in) next_h.power = 1'b1;
		else if (h.sleep_seen) next_h.power = 1'b0;
		case (h.st)
			IMC_H_IDLE: begin
				if (take) begin
					next_h.st = IMC_H_SHIFT;
					next_h.csn = 1'b0;
					next_h.div = '0;
					next_h.bitn = '0;
					next_h.addr = req_addr_in;
					next_h.rd = !req_write_in;
					next_h.sh = {req_addr_in, req_data_in};
					next_h.last = req_addr_in == `IMC_A_GEN_RESET ? `IMC_ADDR_BITS - 5'd1 :
						`IMC_FRAME_BITS - 5'd1;
					if (req_addr_in == `IMC_A_IMAGE) next_h.words = h.words + 15'd1;
					if (req_addr_in == `IMC_A_GEN_RESET) begin
						next_h.words = '0;
						next_h.ready_seen = 1'b0;
					end
				end
			end
			IMC_H_SHIFT: begin
				next_h.div = h.div + 8'd1;
				if (h.div == SCLK_HALF - 8'd1) begin
					next_h.sclk = 1'b1;
					if (h.rd) next_h.rsh = {h.rsh[14:0], h.rsync[2]};
				end
				if (h.div == 8'(2 * SCLK_HALF - 1)) begin
					next_h.sclk = 1'b0;
					next_h.div = '0;
					next_h.bitn = h.bitn + 5'd1;
					next_h.sh = {h.sh[22:0], 1'b0};
					if (h.bitn == h.last) next_h.st = IMC_H_END;
					else if (h.bitn == `IMC_ADDR_BITS - 5'd1) next_h.st = IMC_H_GAP;
				end
			end
			IMC_H_GAP: begin
				// Lets the device fetch a read word before its bits are clocked
				next_h.div = h.div + 8'd1;
				if (h.div == GAP_CYC) begin
					next_h.div = '0;
					next_h.st = IMC_H_SHIFT;
				end
			end
			default: begin
				next_h.csn = 1'b1;
				next_h.div = h.div + 8'd1;
				if (h.div == GAP_CYC) begin
					next_h.st = IMC_H_IDLE;
					next_h.rsp = 1'b1;
					if (h.rd && h.addr == `IMC_A_STATUS && h.rsh[`IMC_ST_READY]) begin
						next_h.ready_seen = 1'b1;
					end
					if (h.rd && h.addr == `IMC_A_SECONDARY_STATUS) begin
						next_h.sleep_seen = h.rsh[`IMC_ST2_SLEEP];
					end
				end
			end
		endcase
	end

	// Chip select and power come up high so the device starts idle
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			h <= '0;
			h.csn <= 1'b1;
			h.power <= 1'b1;
			h.rsync <= 3'h7;
			h.isync <= 3'h7;
		end else if (clk_en_in) begin
			h <= next_h;
		end
	end

	assign link.sclk = h.sclk;
	assign link.csn = h.csn;
	assign link.cdata = h.sh[23];
	assign link.slot_pulse = h.slot < 20'(`IMC_SLOT_HI_CYC);
	assign rsp_valid_out = h.rsp;
	assign rsp_data_out = h.rsh;
	assign analog_power_out = h.power;
	assign irq_out = h.isync[1] == h.isync[2] && !h.isync[2];
endmodule
`default_nettype wire

/* File: tb/imc_link_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module imc_link_properties #(
	parameter logic [19:0] SLOT_CYC = 20'd666667
) (
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	input  wire logic sclk,
	input  wire logic csn,
	input  wire logic cdata,
	input  wire logic rdata_oe,
	input  wire logic slot_pulse,
	input  wire logic irq_dev,
	input  wire logic irq_oe
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	typedef struct packed {
		logic        sclk_q;
		logic        slot_q;
		logic        seen;
		logic [4:0]  bits;
		logic [7:0]  addr;
		logic [7:0]  gap;
		logic [19:0] hi;
		logic [19:0] per;
	} imc_watch_t;
	imc_watch_t      st;
	imc_watch_t      next_st;
	wire logic       rise     = sclk && !st.sclk_q;
	wire logic [4:0] bits_now = st.bits + {4'd0, rise};
	wire logic       is_rd    = st.addr inside {8'ha9, 8'haa, 8'hb8, 8'hb9, 8'hc4, 8'hc5, 8'hc6, 8'hc9};
	////////////////////////////////////////////////////////////////////////////////
	// Bit count and address per frame; the gap counter saturates so a long idle is fine
	always_comb begin
		next_st = st;
		next_st.sclk_q = sclk;
		next_st.slot_q = slot_pulse;
		next_st.seen = st.seen | (slot_pulse & ~st.slot_q);
		next_st.bits = csn ? 5'd0 : bits_now;
		if (rise && !csn && st.bits < 5'd8) begin
			next_st.addr = {st.addr[6:0], cdata};
		end
		if (!csn) begin
			next_st.gap = 8'd0;
		end else if (st.gap != 8'hff) begin
			next_st.gap = st.gap + 8'd1;
		end
		next_st.hi = slot_pulse ? st.hi + 20'd1 : 20'd0;
		next_st.per = (slot_pulse && !st.slot_q) ? 20'd1 : st.per + 20'd1;
	end
	// Gap starts saturated so the first frame after reset is not judged
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= '{gap: 8'hff, default: '0};
		end else begin
			st <= next_st;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	a_frame_bit_count: assert property ($rose(csn) |-> st.bits == 5'd8 || st.bits == 5'd24)
		else $error("frame length wrong");
	a_frame_gap_min: assert property ($fell(csn) |-> st.gap >= 8'd12)
		else $error("frame gap too short");
	a_read_after_addr: assert property (rdata_oe |-> !csn && bits_now >= 5'd8)
		else $error("read data driven outside data phase");
	a_read_select: assert property (rise && bits_now == 5'd9 |-> rdata_oe == is_rd)
		else $error("read enable does not match address");
	a_data_setup: assert property (rise && !csn |-> $stable(cdata))
		else $error("command data moved at clock rise");
	a_slot_high_min: assert property ($fell(slot_pulse) |-> st.hi >= 20'd1250)
		else $error("slot pulse too short");
	a_slot_period: assert property ($rose(slot_pulse) && st.seen |-> st.per == SLOT_CYC)
		else $error("slot period wrong");
	a_irq_drive_low: assert property (irq_oe |-> !irq_dev)
		else $error("interrupt line driven high");
endmodule
`default_nettype wire

/* File: tb/image_activation_mode_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module image_activation_mode_control_test;
	import imc_pkg::*;
	localparam logic [19:0] SLOT = 20'd12000;
	localparam int          TICK = 1041;
	localparam logic [15:0] W [9] = '{16'd4, 16'd1, 16'd2, 16'd2, 16'd3, 16'd4, 16'd6,
		16'd7, 16'd8};
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in   = 1'b1;
	logic        ce         = 1'b1;
	logic        v          = 1'b0;
	logic        w          = 1'b0;
	logic        pwr        = 1'b1;
	logic        sp;
	logic [7:0]  a          = 8'h00;
	logic [15:0] d          = 16'h0000;
	logic [9:0]  aux [2]    = '{10'h000, 10'h000};
	logic        rdy, rsp_v, pwr_out, irq, modu, ramp, txen, sense;
	logic [15:0] rsp, rd, rsr;
	logic [23:0] csr;
	logic [15:0] img [4];
	logic [31:0] sum, sum2;
	logic [3:0]  s, ps;
	imc_mode_t   mode;
	int          mismatches = 0;
	int          cmp_count  = 0;
	// Mode walk: task code, mode after it, and whether it must be refused
	logic [7:0]  tc [8]     = '{8'h81, 8'h82, 8'h02, 8'h01, 8'h82, 8'h02, 8'h83, 8'h81};
	imc_mode_t   tm [8]     = '{IMC_NORMAL, IMC_NORMAL, IMC_CONFIG, IMC_CONFIG, IMC_NORMAL,
		IMC_CONFIG, IMC_SLEEP, IMC_NORMAL};
	logic [7:0]  te         = 8'b0000_1010;
	int          on [4]     = '{1, 2, 3, 4};
	int          off [4]    = '{2, 8, 7, 6};
	int          t_on [4]   = '{-1, -1, -1, -1};
	int          t_off [4]  = '{-1, -1, -1, -1};
	imc_link_if lk ();
	imc_device #(.IMAGE_WORDS(W[0]), .SENSE_ON(W[1]), .SENSE_OFF(W[2]), .TXEN_ON(W[3]),
		.RAMP_ON(W[4]), .MOD_ON(W[5]), .MOD_OFF(W[6]), .RAMP_OFF(W[7]), .TXEN_OFF(W[8]))
	imc_device_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(ce),
		.link(lk.device), .aux_a_in(aux[0]), .aux_b_in(aux[1]), .modulation_out(modu),
		.ramp_up_out(ramp), .tx_enable_out(txen), .carrier_sense_out(sense), .mode_out(mode));
	imc_host #(.IMAGE_WORDS(4), .SLOT_CYC(SLOT)) imc_host_inst (.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in), .clk_en_in(1'b1), .link(lk.host), .req_valid_in(v),
		.req_write_in(w), .req_addr_in(a), .req_data_in(d), .req_ready_out(rdy),
		.rsp_valid_out(rsp_v), .rsp_data_out(rsp), .analog_power_req_in(pwr),
		.analog_power_out(pwr_out), .irq_out(irq));
	imc_link_properties #(.SLOT_CYC(SLOT)) imc_link_properties_inst (.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in), .sclk(lk.sclk), .csn(lk.csn), .cdata(lk.cdata),
		.rdata_oe(lk.rdata_oe), .slot_pulse(lk.slot_pulse), .irq_dev(lk.irq_dev),
		.irq_oe(lk.irq_oe));
	////////////////////////////////////////////////////////////////////////////////
	always #20 sys_clk_in = ~sys_clk_in;
	// Shift both wire directions at the rising link edge, first bit ending up on top
	always @(posedge lk.sclk) begin
		if (!lk.csn) begin
			csr <= {csr[22:0], lk.cdata};
			rsr <= {rsr[14:0], lk.rdata};
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic hang();
		mismatches++;
		stop_test();
	endtask
	// One host request; valid holds until the edge that sees ready, then waits the answer
	task automatic xfer(input logic wr, input logic [7:0] ad, input logic [15:0] dat);
		int n;
		n = 0;
		@(negedge sys_clk_in);
		v = 1'b1;
		w = wr;
		a = ad;
		d = dat;
		while (rdy !== 1'b1) begin
			@(negedge sys_clk_in);
			if (++n > 3000) hang();
		end
		@(negedge sys_clk_in);
		v = 1'b0;
		while (rsp_v !== 1'b1) begin
			@(negedge sys_clk_in);
			if (++n > 3000) hang();
		end
		rd = rsp;
	endtask
	// The host refuses image data until a status read showed ready
	task automatic load();
		sum = 32'h0;
		sum2 = 32'h0;
		xfer(1'b0, 8'hc6, 16'h0);
		check(rd[0], 1'b1);
		for (int i = 0; i < 4; i++) begin
			img[i] = 16'($urandom);
			sum += {16'h0, img[i]};
			sum2 = {sum2[30:0], sum2[31]} ^ 32'(img[i]);
			xfer(1'b1, 8'hc3, img[i]);
		end
		check(csr, {8'hc3, img[3]});
	endtask
	task automatic unlock(input logic [31:0] code);
		xfer(1'b1, 8'hc8, code[31:16]);
		xfer(1'b1, 8'hc8, code[15:0]);
	endtask
	// Burst events land this many cycles after the slot edge; sync delay allowed for
	function automatic int lag(input int got, input int ticks);
		return (got >= ticks * TICK - 2 && got <= ticks * TICK + 8) ? 0 : got;
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h39e3));
		aux[0] = 10'($urandom);
		aux[1] = 10'($urandom);
		#1 rst_n_in = 1'b0;
		repeat (10) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		load();
		xfer(1'b0, 8'hc5, 16'h0);
		check(rd, 16'h00a5);
		xfer(1'b0, 8'hc9, 16'h0);
		check(rd, img[0]);
		xfer(1'b0, 8'ha9, 16'h0);
		check(rd, sum[31:16]);
		xfer(1'b0, 8'haa, 16'h0);
		check(rd, sum[15:0]);
		xfer(1'b0, 8'hb9, 16'h0);
		check(rd, sum2[15:0]);
		$display("test load finished");
		unlock(32'h1234_5678);
		rd = 16'h0;
		for (int n = 0; n < 40 && rd[13] !== 1'b1; n++) xfer(1'b0, 8'hc4, 16'h0);
		check(rd[13], 1'b1);
		check(mode, IMC_SLEEP);
		xfer(1'b0, 8'hc6, 16'h0);
		check(rd[0], 1'b1);
		foreach (tc[i]) begin
			xfer(1'b0, i[0] ? 8'ha9 : 8'hc5, 16'h0);
			if (i < 2) check(rd, 16'h0);
		end
		pwr = 1'b0;
		for (int n = 0; n < 50 && pwr_out !== 1'b0; n++) @(negedge sys_clk_in);
		check(pwr_out, 1'b0);
		pwr = 1'b1;
		for (int n = 0; n < 50 && pwr_out !== 1'b1; n++) @(negedge sys_clk_in);
		$display("test unlock finished");
		foreach (tc[i]) begin
			ce = i != 6;
			xfer(1'b1, 8'hc8, {8'h00, tc[i]});
			check(mode, i == 6 ? IMC_CONFIG : tm[i]);
			ce = 1'b1;
			xfer(1'b0, 8'hc6, 16'h0);
			check(rd[3], te[i]);
		end
		$display("test modes finished");
		xfer(1'b1, 8'h55, 16'hffff);
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, 8'hc1, 16'(k));
			repeat (130) @(negedge sys_clk_in);
			xfer(1'b0, 8'hc9, 16'h0);
			check(rd & 16'h13ff, {3'b0, k[0], 2'b0, aux[k]});
		end
		$display("test converter finished");
		for (int n = 0; n < 13000 && lk.slot_pulse !== 1'b1; n++) @(negedge sys_clk_in);
		xfer(1'b1, 8'hc8, 16'h0501);
		xfer(1'b0, 8'hc6, 16'h0);
		check(rd[2:1], 2'b01);
		sp = 1'b1;
		for (int n = 0; n < 13000 && !(lk.slot_pulse && !sp); n++) begin
			sp = lk.slot_pulse;
			@(negedge sys_clk_in);
		end
		ps = 4'h0;
		for (int t = 1; t < 9 * TICK; t++) begin
			@(negedge sys_clk_in);
			s = {modu, ramp, txen, sense};
			for (int k = 0; k < 4; k++) begin
				if (s[k] && !ps[k]) t_on[k] = t;
				if (!s[k] && ps[k]) t_off[k] = t;
			end
			ps = s;
		end
		for (int k = 0; k < 4; k++) begin
			check(lag(t_on[k], on[k]), 0);
			check(lag(t_off[k], off[k]), 0);
		end
		check(irq, 1'b0);
		xfer(1'b1, 8'hce, 16'h8000);
		for (int n = 0; n < 50 && irq !== 1'b1; n++) @(negedge sys_clk_in);
		check(lk.host_interrupt_line, 1'b0);
		xfer(1'b0, 8'hc6, 16'h0);
		check(rd[2], 1'b1);
		for (int n = 0; n < 50 && irq !== 1'b0; n++) @(negedge sys_clk_in);
		check(irq, 1'b0);
		$display("test burst finished");
		xfer(1'b1, 8'h01, 16'h0);
		check(mode, IMC_LOAD);
		load();
		unlock(32'hedcb_a987);
		xfer(1'b0, 8'ha9, 16'h0);
		check(rd, 16'hdead);
		check(rsr, 16'hdead);
		xfer(1'b1, 8'h01, 16'h0);
		unlock(32'h1234_5678);
		xfer(1'b0, 8'ha9, 16'h0);
		check(rd, 16'hdead);
		$display("test lockout finished");
		rst_n_in = 1'b0;
		repeat (10) @(negedge sys_clk_in);
		rst_n_in = 1'b1;
		check(mode, IMC_LOAD);
		xfer(1'b0, 8'ha9, 16'h0);
		check(rd == 16'hdead, 1'b0);
		$display("test power reset finished");
		stop_test();
	end
endmodule
`default_nettype wire
